/* include/dtr_pkg.sv */
// constants for the converter trim and auxiliary control register bank
// assumes an apb master with 32-bit data; each register is one aligned word
package dtr_pkg;

  // bus geometry
  localparam int unsigned DTR_ADDR_W = 12;
  localparam int unsigned DTR_DATA_W = 32;
  localparam int unsigned DTR_REG_W  = 8;
  localparam int unsigned DTR_SMP_W  = 16;

  // register indices; the byte address is four times the index
  localparam logic [7:0] DTR_IDX_Q_OFS_LO   = 8'h3E;
  localparam logic [7:0] DTR_IDX_Q_OFS_HI   = 8'h3F;
  localparam logic [7:0] DTR_IDX_I_FS_LO    = 8'h40;
  localparam logic [7:0] DTR_IDX_I_CTRL     = 8'h41;
  localparam logic [7:0] DTR_IDX_I_AUX_LO   = 8'h42;
  localparam logic [7:0] DTR_IDX_I_AUX_CTRL = 8'h43;
  localparam logic [7:0] DTR_IDX_Q_FS_LO    = 8'h44;
  localparam logic [7:0] DTR_IDX_Q_CTRL     = 8'h45;
  localparam logic [7:0] DTR_IDX_Q_AUX_LO   = 8'h46;
  localparam logic [7:0] DTR_IDX_Q_AUX_CTRL = 8'h47;
  localparam logic [7:0] DTR_IDX_THERM_RNG  = 8'h48;
  localparam logic [7:0] DTR_IDX_THERM_LO   = 8'h49;
  localparam logic [7:0] DTR_IDX_THERM_HI   = 8'h4A;

  // values after reset
  localparam logic [7:0] DTR_RST_OFS       = 8'h00;
  localparam logic [7:0] DTR_RST_FS_LO     = 8'hF9;
  localparam logic [7:0] DTR_RST_CTRL      = 8'h01;
  localparam logic [7:0] DTR_RST_AUX_LO    = 8'h00;
  localparam logic [7:0] DTR_RST_AUX_CTRL  = 8'h00;
  localparam logic [7:0] DTR_RST_THERM_RNG = 8'h02;

  // writable bit masks; bits outside read as zero
  localparam logic [7:0] DTR_MASK_FULL     = 8'hFF;
  localparam logic [7:0] DTR_MASK_CTRL     = 8'h83;
  localparam logic [7:0] DTR_MASK_AUX_CTRL = 8'hE3;
  localparam logic [7:0] DTR_MASK_RNG      = 8'h7F;

  // field positions
  localparam int unsigned DTR_BIT_SLEEP     = 7;
  localparam int unsigned DTR_BIT_AUX_SIGN  = 7;
  localparam int unsigned DTR_BIT_AUX_DIR   = 6;
  localparam int unsigned DTR_BIT_AUX_SLEEP = 5;
  localparam int unsigned DTR_BIT_CAP       = 0;
  localparam int unsigned DTR_POS_SPAN      = 4;
  localparam int unsigned DTR_POS_REF       = 1;
  localparam int unsigned DTR_FLD3_W        = 3;

endpackage

/* verilog/dtr_offset_adder.sv */
// q-channel sample offset stage: adds the programmed offset to each sample
// assumes samples arrive on the register clock with a one-cycle valid
`timescale 1ns/100ps
module dtr_offset_adder
  import dtr_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire logic [DTR_SMP_W-1:0] sample_in,
  input  wire logic                 sample_valid_in,
  input  wire logic [DTR_SMP_W-1:0] offset_in,
  output logic      [DTR_SMP_W-1:0] sample_out,
  output logic                      sample_valid_out
);

  logic [DTR_SMP_W-1:0] next_sample;

  // modular sum: wraps rather than saturates, as a plain adder would
  always_comb begin
    next_sample = sample_in + offset_in; // R1
  end

  // one register stage keeps the data output off the adder carry chain
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_out       <= 16'h0000;
      sample_valid_out <= 1'b0;
    end else if (ce_in) begin
      sample_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        sample_out <= next_sample;
      end
    end
  end

endmodule

/* verilog/dtr_regs_top.sv */
// apb register bank for converter trims, auxiliary sources and thermal range
// assumes an apb master on ref_clk_in and thermal data from same-clock logic
//
// Behaviour
// R1 - q offset added to every q sample
// R2 - i trim ten bits, resets 0x1F9
// R3 - trim code drives current linearly, min-mid-max
// R4 - i control bit7 puts i converter asleep
// R5 - q trim ten bits, resets 0x1F9
// R6 - q control bit7 puts q converter asleep
// R7 - i aux magnitude ten bits, 2 uA steps
// R8 - i aux bit7 picks output leg
// R9 - i aux bit6 picks source or sink
// R10 - i aux bit5 sleeps i aux source
// R11 - q aux magnitude ten bits, 2 uA steps
// R12 - q aux bit7 picks output leg
// R13 - q aux bit6 picks source or sink
// R14 - q aux bit5 sleeps q aux source
// R15 - thermal span level bits 6..4, reset 000
// R16 - thermal reference level bits 3..1, reset 001
// R17 - thermal capacitance select bit 0, reset 0
// R18 - thermal reading sixteen bits, read only
// R19 - unassigned bits read zero, ignore writes
`timescale 1ns/100ps
module dtr_regs_top
  import dtr_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [DTR_ADDR_W-1:0] paddr_in,
  input  wire logic [DTR_DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic      [DTR_DATA_W-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // q sample path
  input  wire logic [DTR_SMP_W-1:0]  q_sample_in,
  input  wire logic                  q_sample_valid_in,
  output logic      [DTR_SMP_W-1:0]  q_sample_out,
  output logic                       q_sample_valid_out,
  // thermal converter result
  input  wire logic [DTR_SMP_W-1:0]  thermal_value_in,
  // analog controls
  output logic      [9:0]            i_fullscale_trim_out,
  output logic                       i_sleep_out,
  output logic      [9:0]            q_fullscale_trim_out,
  output logic                       q_sleep_out,
  output logic      [9:0]            i_aux_level_out,
  output logic                       i_aux_negative_leg_out,
  output logic                       i_aux_sink_out,
  output logic                       i_aux_sleep_out,
  output logic      [9:0]            q_aux_level_out,
  output logic                       q_aux_negative_leg_out,
  output logic                       q_aux_sink_out,
  output logic                       q_aux_sleep_out,
  output logic      [2:0]            thermal_adc_span_level_out,
  output logic      [2:0]            thermal_adc_ref_level_out,
  output logic                       thermal_adc_large_cap_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a register under its writable mask
  function automatic logic [7:0] dtr_merge(input logic [7:0] old_val,
                                           input logic [7:0] wr_val,
                                           input logic [7:0] mask);
    dtr_merge = (old_val & ~mask) | (wr_val & mask); // R19
  endfunction

  // true when the byte address lands on a mapped register word
  function automatic logic dtr_mapped(input logic [DTR_ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[DTR_ADDR_W-1:2];
    dtr_mapped = (addr[1:0] == 2'h0) &&
                 (idx >= {2'h0, DTR_IDX_Q_OFS_LO}) &&
                 (idx <= {2'h0, DTR_IDX_THERM_HI});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0]  q_channel_offset_low;
  logic [7:0]  q_channel_offset_high;
  logic [7:0]  i_fullscale_trim_low;
  logic [7:0]  i_channel_control;
  logic [7:0]  i_auxiliary_level_low;
  logic [7:0]  i_auxiliary_control;
  logic [7:0]  q_fullscale_trim_low;
  logic [7:0]  q_channel_control;
  logic [7:0]  q_auxiliary_level_low;
  logic [7:0]  q_auxiliary_control;
  logic [7:0]  thermal_range_control;
  logic [7:0]  thermal_high_snapshot;

  logic [7:0]  reg_index;
  logic        addr_ok;
  logic        wr_fire;
  logic        rd_setup;
  logic [7:0]  wbyte;
  logic [7:0]  next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // index only valid when addr_ok; upper index bits are checked there
  assign reg_index = paddr_in[9:2];
  assign addr_ok   = dtr_mapped(paddr_in);
  assign wbyte     = pwdata_in[7:0];

  // no wait states: read data is fetched at the setup edge into a flop
  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // a write lands only at the completing edge and only with lane 0 enabled
  assign wr_fire  = psel_in & penable_in & pwrite_in & addr_ok & pstrb_in[0];
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;

  ////////////////////////////////////////////////////////////////////////////
  // q offset pair

  // the two bytes are independent; software must keep them coherent itself
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_channel_offset_low  <= DTR_RST_OFS;
      q_channel_offset_high <= DTR_RST_OFS;
    end else if (ce_in && wr_fire) begin
      if (reg_index == DTR_IDX_Q_OFS_LO) begin
        q_channel_offset_low <= dtr_merge(q_channel_offset_low, wbyte, DTR_MASK_FULL); // R1
      end
      if (reg_index == DTR_IDX_Q_OFS_HI) begin
        q_channel_offset_high <= dtr_merge(q_channel_offset_high, wbyte, DTR_MASK_FULL); // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i channel trim and sleep

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      i_fullscale_trim_low <= DTR_RST_FS_LO;
      i_channel_control    <= DTR_RST_CTRL;
    end else if (ce_in && wr_fire) begin
      if (reg_index == DTR_IDX_I_FS_LO) begin
        i_fullscale_trim_low <= dtr_merge(i_fullscale_trim_low, wbyte, DTR_MASK_FULL); // R2
      end
      if (reg_index == DTR_IDX_I_CTRL) begin
        i_channel_control <= dtr_merge(i_channel_control, wbyte, DTR_MASK_CTRL); // R4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i auxiliary source

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      i_auxiliary_level_low <= DTR_RST_AUX_LO;
      i_auxiliary_control   <= DTR_RST_AUX_CTRL;
    end else if (ce_in && wr_fire) begin
      if (reg_index == DTR_IDX_I_AUX_LO) begin
        i_auxiliary_level_low <= dtr_merge(i_auxiliary_level_low, wbyte, DTR_MASK_FULL); // R7
      end
      if (reg_index == DTR_IDX_I_AUX_CTRL) begin
        i_auxiliary_control <= dtr_merge(i_auxiliary_control, wbyte, DTR_MASK_AUX_CTRL); // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q channel trim and sleep

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_fullscale_trim_low <= DTR_RST_FS_LO;
      q_channel_control    <= DTR_RST_CTRL;
    end else if (ce_in && wr_fire) begin
      if (reg_index == DTR_IDX_Q_FS_LO) begin
        q_fullscale_trim_low <= dtr_merge(q_fullscale_trim_low, wbyte, DTR_MASK_FULL); // R5
      end
      if (reg_index == DTR_IDX_Q_CTRL) begin
        q_channel_control <= dtr_merge(q_channel_control, wbyte, DTR_MASK_CTRL); // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q auxiliary source

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_auxiliary_level_low <= DTR_RST_AUX_LO;
      q_auxiliary_control   <= DTR_RST_AUX_CTRL;
    end else if (ce_in && wr_fire) begin
      if (reg_index == DTR_IDX_Q_AUX_LO) begin
        q_auxiliary_level_low <= dtr_merge(q_auxiliary_level_low, wbyte, DTR_MASK_FULL); // R11
      end
      if (reg_index == DTR_IDX_Q_AUX_CTRL) begin
        q_auxiliary_control <= dtr_merge(q_auxiliary_control, wbyte, DTR_MASK_AUX_CTRL); // R14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal converter range

  // bit 7 is unassigned and stays zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      thermal_range_control <= DTR_RST_THERM_RNG; // R16
    end else if (ce_in && wr_fire && reg_index == DTR_IDX_THERM_RNG) begin
      thermal_range_control <= dtr_merge(thermal_range_control, wbyte, DTR_MASK_RNG); // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal reading

  // reading the low byte freezes the high byte, so a low-then-high read pair
  // sees one coherent sample even while the converter keeps updating
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      thermal_high_snapshot <= 8'h00;
    end else if (ce_in && rd_setup && addr_ok && reg_index == DTR_IDX_THERM_LO) begin
      thermal_high_snapshot <= thermal_value_in[15:8]; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // unmapped and unassigned bits return zero
  always_comb begin
    next_rdata = 8'h00;
    if (addr_ok) begin
      unique case (reg_index)
        DTR_IDX_Q_OFS_LO:   next_rdata = q_channel_offset_low;
        DTR_IDX_Q_OFS_HI:   next_rdata = q_channel_offset_high;
        DTR_IDX_I_FS_LO:    next_rdata = i_fullscale_trim_low;
        DTR_IDX_I_CTRL:     next_rdata = i_channel_control;
        DTR_IDX_I_AUX_LO:   next_rdata = i_auxiliary_level_low;
        DTR_IDX_I_AUX_CTRL: next_rdata = i_auxiliary_control;
        DTR_IDX_Q_FS_LO:    next_rdata = q_fullscale_trim_low;
        DTR_IDX_Q_CTRL:     next_rdata = q_channel_control;
        DTR_IDX_Q_AUX_LO:   next_rdata = q_auxiliary_level_low;
        DTR_IDX_Q_AUX_CTRL: next_rdata = q_auxiliary_control;
        DTR_IDX_THERM_RNG:  next_rdata = thermal_range_control;
        DTR_IDX_THERM_LO:   next_rdata = thermal_value_in[7:0]; // R18
        DTR_IDX_THERM_HI:   next_rdata = thermal_high_snapshot; // R18
        default:            next_rdata = 8'h00; // R19
      endcase
    end
  end

  // read data is loaded at the setup edge and held through the access phase
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (ce_in && rd_setup) begin
      prdata_out <= {24'h000000, next_rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog control outputs

  // trims are linear codes: 0x000 minimum, 0x200 midpoint, 0x3FF maximum
  assign i_fullscale_trim_out = {i_channel_control[1:0], i_fullscale_trim_low}; // R3
  assign q_fullscale_trim_out = {q_channel_control[1:0], q_fullscale_trim_low}; // R3
  assign i_sleep_out          = i_channel_control[DTR_BIT_SLEEP]; // R4
  assign q_sleep_out          = q_channel_control[DTR_BIT_SLEEP]; // R6

  // auxiliary magnitude: zero gives no current, each code adds one step
  assign i_aux_level_out        = {i_auxiliary_control[1:0], i_auxiliary_level_low}; // R7
  assign i_aux_negative_leg_out = i_auxiliary_control[DTR_BIT_AUX_SIGN]; // R8
  assign i_aux_sink_out         = i_auxiliary_control[DTR_BIT_AUX_DIR]; // R9
  assign i_aux_sleep_out        = i_auxiliary_control[DTR_BIT_AUX_SLEEP]; // R10
  assign q_aux_level_out        = {q_auxiliary_control[1:0], q_auxiliary_level_low}; // R11
  assign q_aux_negative_leg_out = q_auxiliary_control[DTR_BIT_AUX_SIGN]; // R12
  assign q_aux_sink_out         = q_auxiliary_control[DTR_BIT_AUX_DIR]; // R13
  assign q_aux_sleep_out        = q_auxiliary_control[DTR_BIT_AUX_SLEEP]; // R14

  // thermal converter range fields
  assign thermal_adc_span_level_out = thermal_range_control[DTR_POS_SPAN +: DTR_FLD3_W]; // R15
  assign thermal_adc_ref_level_out  = thermal_range_control[DTR_POS_REF +: DTR_FLD3_W]; // R16
  assign thermal_adc_large_cap_out  = thermal_range_control[DTR_BIT_CAP]; // R17

  ////////////////////////////////////////////////////////////////////////////
  // q sample offset stage

  dtr_offset_adder u_q_offset (
    .ref_clk_in       (ref_clk_in),
    .rst_in           (rst_in),
    .ce_in            (ce_in),
    .sample_in        (q_sample_in),
    .sample_valid_in  (q_sample_valid_in),
    .offset_in        ({q_channel_offset_high, q_channel_offset_low}),
    .sample_out       (q_sample_out),
    .sample_valid_out (q_sample_valid_out)
  );

endmodule

/* verif/dtr_regs_top_asserts.sv */
// checker for the converter trim register bank, watching the top ports only
// assumes one clock domain and an apb master holding requests until pready
`timescale 1ns/100ps
module dtr_regs_top_asserts (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic [15:0] q_sample_in,
  input wire logic        q_sample_valid_in,
  input wire logic [15:0] q_sample_out,
  input wire logic        q_sample_valid_out,
  input wire logic [9:0]  i_fullscale_trim_out,
  input wire logic        i_sleep_out,
  input wire logic [9:0]  q_fullscale_trim_out,
  input wire logic        q_sleep_out,
  input wire logic [9:0]  i_aux_level_out,
  input wire logic        i_aux_negative_leg_out,
  input wire logic        i_aux_sink_out,
  input wire logic        i_aux_sleep_out,
  input wire logic [9:0]  q_aux_level_out,
  input wire logic        q_aux_negative_leg_out,
  input wire logic        q_aux_sink_out,
  input wire logic        q_aux_sleep_out,
  input wire logic [2:0]  thermal_adc_span_level_out,
  input wire logic [2:0]  thermal_adc_ref_level_out,
  input wire logic        thermal_adc_large_cap_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // a write that really lands; strobe 0 or frozen clock enable must not count
  wire wr_go = psel_in && penable_in && pwrite_in && pstrb_in[0] && ce_in;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the q offset, rebuilt from bus traffic so the sum is independent
  logic [15:0] ofs;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) ofs <= 16'h0000;
    else if (wr_go && paddr_in == 12'h0F8) ofs[7:0] <= pwdata_in[7:0];
    else if (wr_go && paddr_in == 12'h0FC) ofs[15:8] <= pwdata_in[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  a_offset_sum : assert property (
    q_sample_valid_in && ce_in |=> q_sample_valid_out && q_sample_out == $past(q_sample_in) + $past(ofs))
    else $error("offset sum wrong or late");
  a_itrim_write : assert property (
    wr_go && paddr_in == 12'h100 |=> i_fullscale_trim_out[7:0] == $past(pwdata_in[7:0]))
    else $error("i trim low byte not loaded");
  a_itrim_hold : assert property (
    !(wr_go && (paddr_in == 12'h100 || paddr_in == 12'h104)) |=> $stable(i_fullscale_trim_out))
    else $error("i trim changed without a write");
  a_ictrl_write : assert property (
    wr_go && paddr_in == 12'h104 |=> {i_sleep_out, i_fullscale_trim_out[9:8]} == {$past(pwdata_in[7]), $past(pwdata_in[1:0])})
    else $error("i control not loaded");
  a_qctrl_write : assert property (
    wr_go && paddr_in == 12'h114 |=> {q_sleep_out, q_fullscale_trim_out[9:8]} == {$past(pwdata_in[7]), $past(pwdata_in[1:0])})
    else $error("q control not loaded");
  a_iaux_ctrl : assert property (
    wr_go && paddr_in == 12'h10C |=> {i_aux_negative_leg_out, i_aux_sink_out, i_aux_sleep_out, i_aux_level_out[9:8]}
      == {$past(pwdata_in[7:5]), $past(pwdata_in[1:0])})
    else $error("i aux control not loaded");
  a_qaux_ctrl : assert property (
    wr_go && paddr_in == 12'h11C |=> {q_aux_negative_leg_out, q_aux_sink_out, q_aux_sleep_out, q_aux_level_out[9:8]}
      == {$past(pwdata_in[7:5]), $past(pwdata_in[1:0])})
    else $error("q aux control not loaded");
  a_range_write : assert property (
    wr_go && paddr_in == 12'h120 |=> {thermal_adc_span_level_out, thermal_adc_ref_level_out, thermal_adc_large_cap_out}
      == $past(pwdata_in[6:0]))
    else $error("thermal range not loaded");
  a_upper_zero : assert property (
    prdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // main scenarios reached
  c_write : cover property (wr_go);
  c_sample : cover property (q_sample_valid_in ##1 q_sample_valid_out);
  c_thermal : cover property (psel_in && penable_in && !pwrite_in && paddr_in == 12'h124);
endmodule

bind dtr_regs_top dtr_regs_top_asserts i_chk (.*);

/* verif/dtr_regs_top_bench.sv */
// self-checking bench for the converter trim register bank
// assumes the checker is bound by its own file; clock enable held high except for one dropped write in test_fields
`timescale 1ns/100ps
module dtr_regs_top_bench;
  logic        ref_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
  logic [3:0]  pstrb_in = 4'h1;
  logic        pready_out, pslverr_out, q_sample_valid_in = 1'b0, q_sample_valid_out, err;
  logic [15:0] q_sample_in = 16'h0000, q_sample_out, thermal_value_in = 16'hA55A;
  logic [9:0]  i_fullscale_trim_out, q_fullscale_trim_out, i_aux_level_out, q_aux_level_out;
  logic        i_sleep_out, q_sleep_out, i_aux_negative_leg_out, i_aux_sink_out, i_aux_sleep_out;
  logic        q_aux_negative_leg_out, q_aux_sink_out, q_aux_sleep_out, thermal_adc_large_cap_out;
  logic [2:0]  thermal_adc_span_level_out, thermal_adc_ref_level_out;
  int          failures = 0, tests_run = 0, cycles = 0;
  logic [7:0]  idx_t [11] = '{8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
  logic [7:0]  rst_t [11] = '{8'h00, 8'h00, 8'hF9, 8'h01, 8'h00, 8'h00, 8'hF9, 8'h01, 8'h00, 8'h00, 8'h02};
  logic [7:0]  msk_t [11] = '{8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hFF, 8'hE3, 8'hFF, 8'h83, 8'hFF, 8'hE3, 8'h7F};

  dtr_regs_top i_dut (.*);

  // 20 MHz clock and a hang guard well above the expected run length
  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= {2'b00, idx, 2'b00};
    pwdata_in <= {24'h000000, wd};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  function automatic logic [7:0] flags();
    return {i_sleep_out, q_sleep_out, i_aux_negative_leg_out, i_aux_sink_out, i_aux_sleep_out,
            q_aux_negative_leg_out, q_aux_sink_out, q_aux_sleep_out};
  endfunction

  // one sample through the offset stage; valid must last exactly one cycle
  task automatic send(input logic [15:0] s, input logic [15:0] exp);
    @(posedge ref_clk_in);
    q_sample_in <= s;
    q_sample_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    q_sample_valid_in <= 1'b0;
    @(negedge ref_clk_in);
    chk(32'({q_sample_valid_out, q_sample_out}), 32'({1'b1, exp}));
    @(negedge ref_clk_in);
    chk(32'(q_sample_valid_out), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    for (int i = 0; i < 11; i++) rd_chk(idx_t[i], 32'(rst_t[i]));
    chk(32'({i_fullscale_trim_out, q_fullscale_trim_out}), 32'h7E5F9);
    chk(32'({thermal_adc_span_level_out, thermal_adc_ref_level_out, thermal_adc_large_cap_out}), 32'h02);
    $display("reset values done");
  endtask

  // all ones then all zeros: masks on read, extremes on every control output
  task automatic test_masks();
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h00 : 8'hFF;
      for (int i = 0; i < 11; i++) apb(1'b1, idx_t[i], v);
      for (int i = 0; i < 11; i++) rd_chk(idx_t[i], 32'(v & msk_t[i]));
      @(negedge ref_clk_in);
      chk(32'(flags()), 32'(v));
      chk(32'({i_fullscale_trim_out, q_fullscale_trim_out}), 32'({v[1:0], v, v[1:0], v}));
      chk(32'({i_aux_level_out, q_aux_level_out}), 32'({v[1:0], v, v[1:0], v}));
      chk(32'({thermal_adc_span_level_out, thermal_adc_ref_level_out, thermal_adc_large_cap_out}), 32'(v[6:0]));
    end
    $display("masks and extremes done");
  endtask

  // distinct patterns so that swapped or shifted fields show up
  task automatic test_fields();
    apb(1'b1, 8'h41, 8'h02);
    apb(1'b1, 8'h43, 8'h81);
    apb(1'b1, 8'h42, 8'h5A);
    apb(1'b1, 8'h47, 8'h42);
    apb(1'b1, 8'h46, 8'h01);
    apb(1'b1, 8'h45, 8'h81);
    apb(1'b1, 8'h48, 8'h4D);
    @(negedge ref_clk_in);
    chk(32'({i_sleep_out, i_fullscale_trim_out}), 32'h200);
    chk(32'({i_aux_negative_leg_out, i_aux_sink_out, i_aux_sleep_out, i_aux_level_out}), 32'h115A);
    chk(32'({q_aux_negative_leg_out, q_aux_sink_out, q_aux_sleep_out, q_aux_level_out}), 32'hA01);
    chk(32'({q_sleep_out, q_fullscale_trim_out}), 32'h500);
    chk(32'({thermal_adc_span_level_out, thermal_adc_ref_level_out, thermal_adc_large_cap_out}), 32'h4D);
    apb(1'b1, 8'h47, 8'h20);
    @(negedge ref_clk_in);
    chk(32'({q_aux_negative_leg_out, q_aux_sink_out, q_aux_sleep_out, q_aux_level_out}), 32'h401);
    pstrb_in <= 4'h0;
    apb(1'b1, 8'h40, 8'h33);
    pstrb_in <= 4'h1;
    rd_chk(8'h40, 32'h00);
    // a frozen clock enable must drop a write even though pready still answers
    ce_in <= 1'b0;
    apb(1'b1, 8'h40, 8'h77);
    ce_in <= 1'b1;
    rd_chk(8'h40, 32'h00);
    $display("field placement done");
  endtask

  task automatic test_offset();
    apb(1'b1, 8'h3E, 8'h34);
    apb(1'b1, 8'h3F, 8'h12);
    send(16'hFFF0, 16'h1224);
    apb(1'b1, 8'h3F, 8'h80);
    send(16'h1000, 16'h9034);
    $display("q offset done");
  endtask

  // thermal reading is read only; unmapped places answer with an error
  task automatic test_thermal();
    rd_chk(8'h49, 32'h5A);
    thermal_value_in <= 16'h1234;
    rd_chk(8'h4A, 32'hA5);
    apb(1'b1, 8'h49, 8'hFF);
    rd_chk(8'h49, 32'h34);
    apb(1'b0, 8'h3D, 8'h00);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h4B, 8'h00);
    chk(32'(err), 32'h1);
    $display("thermal and unmapped done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    test_reset();
    test_masks();
    test_fields();
    test_offset();
    test_thermal();
    print_verdict();
  end
endmodule
